// ### verif/rtcef_host.sv
// Purpose: host side of the register port
// Assumes: strobes change at the falling edge
// Notes: one access per two cycles, data released as its inverse
`timescale 1ns/1ps
module rtcef_host (
	// Clock
	input wire logic ref_clk_in,
	// Register port
	output logic reg_rd_out = 1'b0,
	output logic reg_wr_out = 1'b0,
	output logic [7:0] reg_addr_out = 8'h00,
	output logic [7:0] reg_wdata_out = 8'h00,
	input wire logic [7:0] reg_rdata_in,
	input wire logic reg_rvalid_in
);
	task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
		@(negedge ref_clk_in);
		reg_rd_out = !wr;
		reg_wr_out = wr;
		reg_addr_out = a;
		reg_wdata_out = d;
		@(negedge ref_clk_in);
		reg_rd_out = 1'b0;
		reg_wr_out = 1'b0;
		reg_wdata_out = ~d;
		// Answer stands from the taking edge until the next one
		q = reg_rvalid_in ? reg_rdata_in : 8'hXX;
	endtask
endmodule // rtcef_host

// ### verif/rtcef_status_sva.sv
// Purpose: port checker for rtcef_status
// Assumes: read data answers one cycle after the strobe
// Notes: bound at the foot of this file
`timescale 1ns/1ps
module rtcef_status_sva (
	// Watched ports
	input wire logic ref_clk_in,
	input wire logic rst_b_in,
	input wire logic reg_rd_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [7:0] reg_rdata_out,
	input wire logic irq_b_out,
	input wire logic update_end_in,
	input wire logic alarm_match_in,
	input wire logic periodic_tick_in,
	input wire logic backup_source_valid_in
);
	logic re;
	logic ri;
	logic ev;
	assign re = reg_rd_in && reg_addr_in == 8'h0C;
	assign ri = reg_rd_in && reg_addr_in == 8'h0D;
	assign ev = update_end_in || alarm_match_in || periodic_tick_in;
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!rst_b_in);
	AST_EVT_LOW: assert property (re |=> reg_rdata_out[3:0] == 4'h0) else $error("event low bits");
	AST_INT_LOW: assert property (ri |=> reg_rdata_out[6:0] == 7'h00) else $error("integ low bits");
	AST_VALID: assert property (ri |=> reg_rdata_out[7] == $past(backup_source_valid_in)) else $error("valid");
	AST_UPD: assert property (update_end_in ##1 re |=> reg_rdata_out[4]) else $error("update flag");
	AST_ALM: assert property (alarm_match_in ##1 re |=> reg_rdata_out[5]) else $error("alarm flag");
	AST_PER: assert property (periodic_tick_in ##1 re |=> reg_rdata_out[6]) else $error("periodic flag");
	AST_CLR: assert property ((re && !ev) ##1 re |=> reg_rdata_out[7:4] == 4'h0) else $error("clear");
	AST_IRQ: assert property (re |=> reg_rdata_out[7] == !irq_b_out) else $error("irq pin");
endmodule // rtcef_status_sva

bind rtcef_status rtcef_status_sva u_sva (.ref_clk_in, .rst_b_in, .reg_rd_in, .reg_addr_in, .reg_rdata_out,
	.irq_b_out, .update_end_in, .alarm_match_in, .periodic_tick_in, .backup_source_valid_in);

// ### verif/rtcef_status_tb.sv
// Purpose: self-checking bench for rtcef_status
// Assumes: host model issues one access at a time
// Notes: events are driven directly as one-cycle pulses
`timescale 1ns/1ps
module rtcef_status_tb;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic rd, wr, rv, irq_b;
	logic valid = 1'b1;
	logic [7:0] addr, wd, rdata, r;
	logic [2:0] ev = 3'h0;
	logic [3:0] rate;
	int err_count = 0;
	int compares = 0;
	always #12.5 clk = ~clk;
	rtcef_host HOST (.ref_clk_in(clk), .reg_rd_out(rd), .reg_wr_out(wr), .reg_addr_out(addr),
		.reg_wdata_out(wd), .reg_rdata_in(rdata), .reg_rvalid_in(rv));
	rtcef_status DUT (.ref_clk_in(clk), .rst_b_in(rst_b), .reg_rd_in(rd), .reg_wr_in(wr), .reg_addr_in(addr),
		.reg_wdata_in(wd), .reg_rdata_out(rdata), .reg_rvalid_out(rv), .update_end_in(ev[0]),
		.alarm_match_in(ev[1]), .periodic_tick_in(ev[2]), .backup_source_valid_in(valid),
		.rate_select_out(rate), .irq_b_out(irq_b));
	task chk(input string n, input logic [7:0] e, input logic [7:0] s);
		compares++;
		if (s !== e) begin
			err_count++;
			$display("[ERR] %s exp %h got %h", n, e, s);
		end
	endtask
	task pulse(input logic [2:0] m);
		@(negedge clk);
		ev = m;
		@(negedge clk);
		ev = 3'h0;
	endtask
	task t_events();
		HOST.acc(1'b1, 8'h0B, 8'h70, r);
		for (int i = 0; i < 3; i++) begin
			pulse(3'h1 << i);
			@(posedge clk);
			#1 chk("irq_b set", 8'h00, {7'h0, irq_b});
			HOST.acc(1'b0, 8'h0C, 8'h00, r);
			chk("event", 8'h80 | (8'h10 << i), r);
			HOST.acc(1'b0, 8'h0C, 8'h00, r);
			chk("cleared", 8'h00, r);
			chk("irq_b free", 8'h01, {7'h0, irq_b});
		end
	endtask
	task t_mask();
		HOST.acc(1'b1, 8'h0B, 8'h90, r);
		HOST.acc(1'b0, 8'h0B, 8'h00, r);
		chk("ctrl", 8'h80, r);
		pulse(3'h7);
		HOST.acc(1'b1, 8'h0C, 8'h0F, r);
		HOST.acc(1'b0, 8'h0C, 8'h00, r);
		chk("masked", 8'h70, r);
		HOST.acc(1'b1, 8'h0C, 8'hFF, r);
		HOST.acc(1'b0, 8'h0C, 8'h00, r);
		chk("ro event", 8'h00, r);
		for (int i = 0; i < 2; i++) begin
			valid = i[0];
			HOST.acc(1'b1, 8'h0D, 8'h7F, r);
			HOST.acc(1'b0, 8'h0D, 8'h00, r);
			chk("integrity", {i[0], 7'h00}, r);
		end
		HOST.acc(1'b1, 8'h0A, 8'h0B, r);
		// Rate pin is one flop behind the stored byte
		@(negedge clk);
		chk("rate", 8'h0B, {4'h0, rate});
	endtask
	task complete_run();
		$display("errors %0d compares %0d", err_count, compares);
		if (err_count == 0 && compares > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	initial begin
		repeat (3) @(negedge clk);
		rst_b = 1'b1;
		t_events();
		t_mask();
		complete_run();
	end
endmodule // rtcef_status_tb

// ### verilog/rtcef_defs.svh
// Purpose: constants for the event status flag block
// Assumes: byte-wide register port, offsets as printed
// Notes: offsets, flag bit positions and ctrl/rate reset values live here; the ctrl enable bits 4-6 are coded in rtcef_status
`ifndef RTCEF_DEFS_SVH
`define RTCEF_DEFS_SVH
`define RTCEF_OFS_RATE 8'h0A
`define RTCEF_OFS_CTRL 8'h0B
`define RTCEF_OFS_EVENT 8'h0C
`define RTCEF_OFS_INTEG 8'h0D
`define RTCEF_BIT_UPDATE 4
`define RTCEF_BIT_ALARM 5
`define RTCEF_BIT_PERIODIC 6
`define RTCEF_BIT_IRQ 7
`define RTCEF_BIT_VALID 7
`define RTCEF_BIT_INHIBIT 7
`define RTCEF_RATE_LSB 0
`define RTCEF_RATE_MSB 3
`define RTCEF_CTRL_RST 8'h00
`define RTCEF_RATE_RST 8'h00
`endif

// ### verilog/rtcef_pkg.sv
// Purpose: types for the event status flag block
// Assumes: used together with rtcef_defs.svh
// Notes: access cycle kinds of the register port
package rtcef_pkg;
	typedef logic [7:0] rtcef_byte_t;
	typedef enum logic [2:0] {
		RTCEF_IDLE = 3'h1,
		RTCEF_RD = 3'h2,
		RTCEF_WR = 3'h4
	} rtcef_acc_e;
endpackage

// ### verilog/rtcef_status.sv
// Purpose: event status and backup integrity status bytes of a real-time clock
// Assumes: register port already decoded from the multiplexed bus, one-cycle strobes
// Notes: events arrive as one-cycle pulses from the time base logic
`timescale 1ns/1ps
`include "rtcef_defs.svh"

module rtcef_status
	import rtcef_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic rst_b_in,
	// Register port
	input wire logic reg_rd_in,
	input wire logic reg_wr_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	output logic [7:0] reg_rdata_out,
	output logic reg_rvalid_out,
	// Event sources
	input wire logic update_end_in,
	input wire logic alarm_match_in,
	input wire logic periodic_tick_in,
	input wire logic backup_source_valid_in,
	// Control views
	output logic [3:0] rate_select_out,
	output logic irq_b_out
);
	rtcef_byte_t ctrl_r;
	rtcef_byte_t rate_r;
	logic update_ended_flag_r;
	logic alarm_event_flag_r;
	logic periodic_event_flag_r;
	logic irq_request_flag_r;
	logic irq_request_nxt;
	logic event_rd;
	logic periodic_irq_enable;
	logic alarm_irq_enable;
	logic update_irq_enable;
	rtcef_acc_e acc;

	always_comb begin
		if (reg_rd_in) begin
			acc = RTCEF_RD;
		end else if (reg_wr_in) begin
			acc = RTCEF_WR;
		end else begin
			acc = RTCEF_IDLE;
		end
	end

	assign event_rd = (acc == RTCEF_RD) && (reg_addr_in == `RTCEF_OFS_EVENT);
	assign periodic_irq_enable = ctrl_r[6];
	assign alarm_irq_enable = ctrl_r[5];
	assign update_irq_enable = ctrl_r[4];

	// Control byte; only this and the rate byte accept writes
	always_ff @(posedge ref_clk_in) begin
		if (!rst_b_in) begin
			ctrl_r <= `RTCEF_CTRL_RST;
		end else begin
			if (acc == RTCEF_WR && reg_addr_in == `RTCEF_OFS_CTRL) begin
				ctrl_r <= reg_wdata_in;
			end else if (ctrl_r[`RTCEF_BIT_INHIBIT]) begin
				ctrl_r[`RTCEF_BIT_UPDATE] <= 1'b0;
			end
			if (acc == RTCEF_WR && reg_addr_in == `RTCEF_OFS_CTRL && reg_wdata_in[`RTCEF_BIT_INHIBIT]) begin
				ctrl_r[`RTCEF_BIT_UPDATE] <= 1'b0;
			end
		end
	end

	// Rate byte is only stored; the divider lives outside
	always_ff @(posedge ref_clk_in) begin
		if (!rst_b_in) begin
			rate_r <= `RTCEF_RATE_RST;
		end else if (acc == RTCEF_WR && reg_addr_in == `RTCEF_OFS_RATE) begin
			rate_r <= reg_wdata_in;
		end
	end

	// Event flags; writes to the event byte are simply not decoded
	rtcef_flag #(
		.RST_VAL(1'b0)
	) u_update_flag (
		.ref_clk_in(ref_clk_in),
		.rst_b_in(rst_b_in),
		.set_in(update_end_in),
		.clr_in(event_rd),
		.flag_out(update_ended_flag_r)
	);

	rtcef_flag #(
		.RST_VAL(1'b0)
	) u_alarm_flag (
		.ref_clk_in(ref_clk_in),
		.rst_b_in(rst_b_in),
		.set_in(alarm_match_in),
		.clr_in(event_rd),
		.flag_out(alarm_event_flag_r)
	);

	rtcef_flag #(
		.RST_VAL(1'b0)
	) u_periodic_flag (
		.ref_clk_in(ref_clk_in),
		.rst_b_in(rst_b_in),
		.set_in(periodic_tick_in),
		.clr_in(event_rd),
		.flag_out(periodic_event_flag_r)
	);

	// Request flag looks at flags after this cycle's sets
	always_comb begin
		irq_request_nxt = (alarm_irq_enable && (alarm_event_flag_r || alarm_match_in))
			|| (periodic_irq_enable && (periodic_event_flag_r || periodic_tick_in))
			|| (update_irq_enable && (update_ended_flag_r || update_end_in));
	end

	always_ff @(posedge ref_clk_in) begin
		if (!rst_b_in) begin
			irq_request_flag_r <= 1'b0;
		end else if (event_rd) begin
			// Only a fresh event during the read survives the clear
			irq_request_flag_r <= (alarm_irq_enable && alarm_match_in)
				|| (periodic_irq_enable && periodic_tick_in)
				|| (update_irq_enable && update_end_in);
		end else if (irq_request_nxt) begin
			irq_request_flag_r <= 1'b1;
		end
	end

	// Pin mirrors the flag one cycle later, so it stays a flop output
	always_ff @(posedge ref_clk_in) begin
		if (!rst_b_in) begin
			irq_b_out <= 1'b1;
		end else begin
			irq_b_out <= !irq_request_flag_r;
		end
	end

	// Read data registered; unmapped addresses read zero
	always_ff @(posedge ref_clk_in) begin
		if (!rst_b_in) begin
			reg_rdata_out <= 8'h00;
			reg_rvalid_out <= 1'b0;
		end else begin
			reg_rvalid_out <= (acc == RTCEF_RD);
			if (acc != RTCEF_RD) begin
				reg_rdata_out <= 8'h00;
			end else if (reg_addr_in == `RTCEF_OFS_EVENT) begin
				reg_rdata_out <= {irq_request_flag_r, periodic_event_flag_r,
					alarm_event_flag_r, update_ended_flag_r, 4'h0};
			end else if (reg_addr_in == `RTCEF_OFS_INTEG) begin
				reg_rdata_out <= {backup_source_valid_in, 7'h00};
			end else if (reg_addr_in == `RTCEF_OFS_CTRL) begin
				reg_rdata_out <= ctrl_r;
			end else if (reg_addr_in == `RTCEF_OFS_RATE) begin
				reg_rdata_out <= rate_r;
			end else begin
				reg_rdata_out <= 8'h00;
			end
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (!rst_b_in) begin
			rate_select_out <= 4'h0;
		end else begin
			rate_select_out <= rate_r[`RTCEF_RATE_MSB:`RTCEF_RATE_LSB];
		end
	end

endmodule // rtcef_status

module rtcef_flag #(
	parameter logic RST_VAL = 1'b0
) (
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic rst_b_in,
	// Set and clear strobes
	input wire logic set_in,
	input wire logic clr_in,
	// Flag
	output logic flag_out
);
	// Set beats the clear so an event during the clearing read is kept
	always_ff @(posedge ref_clk_in) begin
		if (!rst_b_in) begin
			flag_out <= RST_VAL;
		end else if (set_in) begin
			flag_out <= 1'b1;
		end else if (clr_in) begin
			flag_out <= 1'b0;
		end
	end
endmodule // rtcef_flag
